/* src/dpwm_top.sv */
// dual 12-bit pulse width output unit with an AXI4-Lite register slave
`include "dpwm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dpwm_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output var  logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output var  logic                s_axi_wready,
    output var  dpwm_pkg::dpwm_resp_t s_axi_bresp,
    output var  logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output var  logic                s_axi_arready,
    output var  logic [31:0]         s_axi_rdata,
    output var  dpwm_pkg::dpwm_resp_t s_axi_rresp,
    output var  logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output var  logic [1:0]          pwm_out
);
    import dpwm_pkg::*;

    localparam int NCH = `DPWM_CHANS;

    // bus side: handshake state and the held write
    dpwm_wst_t                 wst_q;
    logic                      awready_q;
    logic                      wready_q;
    logic                      aw_have_q;
    logic                      w_have_q;
    logic [ADDR_W-1:0]         waddr_q;
    logic [31:0]               wdata_q;
    logic [3:0]                wstrb_q;
    logic                      bvalid_q;
    dpwm_resp_t                bresp_q;
    logic                      arready_q;
    logic                      rvalid_q;
    logic [31:0]               rdata_q;
    dpwm_resp_t                rresp_q;
    // unit side: registers, counter and channel taps
    logic [`DPWM_CTRL_W-1:0]   ctrl_q;
    logic                      frc_run_q;
    logic [NCH-1:0]            wr_q;
    dpwm_width_t               wval_q;
    logic                      div_q;
    logic                      tick_q;
    logic [11:0]               frc_q;
    logic [NCH-1:0]            pin_w;
    logic [NCH-1:0]            act_w;
    logic                      aw_hs;
    logic                      w_hs;
    logic                      ar_hs;
    logic                      do_wr;
    logic                      full_word;
    logic                      div_lim;

    // handshakes, and a write that has both halves and may commit
    assign aw_hs     = s_axi_awvalid && awready_q;
    assign w_hs      = s_axi_wvalid && wready_q;
    assign ar_hs     = s_axi_arvalid && arready_q;
    assign do_wr     = wst_q == W_IDLE && aw_have_q && w_have_q;
    assign full_word = wstrb_q[1:0] == 2'h3;

    // write channel: address and data taken in either order, then answer
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wst_q     <= W_IDLE;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            waddr_q   <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
        end else begin
            case (wst_q)
                W_IDLE: begin
                    if (aw_hs) begin
                        waddr_q   <= s_axi_awaddr;
                        aw_have_q <= 1'b1;
                    end
                    if (w_hs) begin
                        wdata_q  <= s_axi_wdata;
                        wstrb_q  <= s_axi_wstrb;
                        w_have_q <= 1'b1;
                    end
                    awready_q <= !aw_have_q && !aw_hs && !do_wr;
                    wready_q  <= !w_have_q && !w_hs && !do_wr;
                    if (do_wr) begin
                        bvalid_q <= 1'b1;
                        wst_q    <= W_RESP;
                    end
                end
                // readies return only as the answer is taken: one write
                W_RESP: begin
                    aw_have_q <= 1'b0;
                    w_have_q  <= 1'b0;
                    if (s_axi_bready) begin
                        bvalid_q  <= 1'b0;
                        awready_q <= 1'b1;
                        wready_q  <= 1'b1;
                        wst_q     <= W_IDLE;
                    end
                end
                default: wst_q <= W_IDLE;
            endcase
        end
    end

    // register writes; width needs both low byte lanes or is dropped
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q    <= `DPWM_CTRL_RST;
            frc_run_q <= `DPWM_TMC_RST;
            wr_q      <= '0;
            wval_q    <= 12'h000;
            bresp_q   <= `DPWM_RESP_OKAY;
        end else begin
            wr_q <= '0;
            if (do_wr) begin
                bresp_q <= `DPWM_RESP_OKAY;
                if (waddr_q == `DPWM_OFF_CTRL) begin
                    if (wstrb_q[0])
                        ctrl_q <= wdata_q[`DPWM_CTRL_W-1:0];
                end else if (waddr_q == `DPWM_OFF_W0) begin
                    wval_q  <= wdata_q[`DPWM_WF_MSB:`DPWM_WF_LSB];
                    wr_q[0] <= full_word;
                end else if (waddr_q == `DPWM_OFF_W1) begin
                    wval_q  <= wdata_q[`DPWM_WF_MSB:`DPWM_WF_LSB];
                    wr_q[1] <= full_word;
                end else if (waddr_q == `DPWM_OFF_TMC) begin
                    if (wstrb_q[0])
                        frc_run_q <= wdata_q[`DPWM_BIT_FRC_RUN];
                end else if (waddr_q != `DPWM_OFF_STAT) begin
                    bresp_q <= `DPWM_RESP_SLVERR;
                end
            end
        end
    end

    // read channel: one answer per address, one cycle after it is taken
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `DPWM_RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= `DPWM_RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
            if (s_axi_araddr == `DPWM_OFF_CTRL) begin
                rdata_q[`DPWM_CTRL_W-1:0] <= ctrl_q;
            end else if (s_axi_araddr == `DPWM_OFF_W0 ||
                         s_axi_araddr == `DPWM_OFF_W1) begin
                rdata_q <= 32'h0000_0000;
            end else if (s_axi_araddr == `DPWM_OFF_TMC) begin
                rdata_q[`DPWM_BIT_FRC_RUN] <= frc_run_q;
            end else if (s_axi_araddr == `DPWM_OFF_STAT) begin
                rdata_q[1:0]  <= act_w;
                rdata_q[3:2]  <= pin_w;
                rdata_q[15:4] <= frc_q;
            end else begin
                rresp_q <= `DPWM_RESP_SLVERR;
            end
        end else if (rvalid_q) begin
            if (s_axi_rready) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end else begin
            arready_q <= 1'b1;
        end
    end

    // rate divider: fast carrier ticks every clock, slow one every second
    // clock, keeping the two carriers a factor of two apart
    // a halt also clears the divider, so a restart begins on a whole tick
    assign div_lim = ctrl_q[`DPWM_BIT_FAST] ? `DPWM_DIV_FAST
                                            : `DPWM_DIV_SLOW;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q  <= 1'b0;
            tick_q <= 1'b0;
        end else if (!frc_run_q) begin
            div_q  <= 1'b0;
            tick_q <= 1'b0;
        end else if (div_q >= div_lim) begin
            div_q  <= 1'b0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // pulse counter: low byte is position in the cycle, top nibble
    // counts the 16 cycles; a halted counter is cleared
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            frc_q <= 12'h000;
        else if (!frc_run_q)
            frc_q <= 12'h000;
        else if (tick_q)
            frc_q <= frc_q + 12'h001;
    end

    // one channel per output pin, all sharing the counter
    for (genvar n = 0; n < NCH; n++) begin : g_ch
        dpwm_ch_if u_if ();
        assign u_if.tick   = tick_q;
        assign u_if.frc_on = frc_run_q;
        assign u_if.cnt    = frc_q;
        assign u_if.run    = ctrl_q[`DPWM_BIT_RUN0 + n];
        assign u_if.pol    = ctrl_q[`DPWM_BIT_POL0 + n];
        assign u_if.sync   = ctrl_q[`DPWM_BIT_SYNC0 + n];
        assign u_if.wr     = wr_q[n];
        assign u_if.wdata  = wval_q;
        assign pin_w[n]    = u_if.pin;
        assign act_w[n]    = u_if.active;
        dpwm_chan u_chan (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .ch      (u_if.chan)
        );
    end

    // outputs come from the flops above and in the channels
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign pwm_out       = pin_w;

    // write answer stands until taken; width reads give zero; counter halt, step and rates
    chk_bresp_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q))
        else $error("write answer dropped before taken");
    chk_width_noread: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ar_hs && (s_axi_araddr == `DPWM_OFF_W0 ||
                  s_axi_araddr == `DPWM_OFF_W1)
        |=> rvalid_q && rdata_q == 32'h0000_0000)
        else $error("width register read back its contents");
    chk_frc_halt: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !frc_run_q |=> !tick_q && frc_q == 12'h000)
        else $error("counter moved while halted");
    chk_slow_rate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tick_q && !ctrl_q[`DPWM_BIT_FAST] && frc_run_q |=> !tick_q)
        else $error("slow carrier ticked on consecutive clocks");
    chk_frc_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tick_q && frc_run_q |=> frc_q == $past(frc_q) + 12'h001)
        else $error("counter did not advance on tick");
    chk_fast_rate: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        frc_run_q && ctrl_q[`DPWM_BIT_FAST] |=> tick_q)
        else $error("fast carrier missed a tick");

    // one write and one read in flight; taking the answer frees the channel
    chk_write_single: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        bvalid_q |-> !awready_q && !wready_q)
        else $error("write taken while an answer is pending");
    chk_write_free: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        bvalid_q && s_axi_bready |=> !bvalid_q && awready_q && wready_q)
        else $error("write channel not freed after answer");
    chk_read_single: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rvalid_q |-> !arready_q)
        else $error("read taken while data is pending");
    chk_rdata_hold: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rvalid_q && !s_axi_rready |=> rvalid_q && $stable(rdata_q) &&
                                       $stable(rresp_q))
        else $error("read data dropped before taken");

    // register side effects of an accepted write, and the status read
    chk_ctrl_write: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        do_wr && waddr_q == `DPWM_OFF_CTRL && wstrb_q[0]
        |=> ctrl_q == $past(wdata_q[`DPWM_CTRL_W-1:0]))
        else $error("control write not applied");
    chk_tmc_write: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        do_wr && waddr_q == `DPWM_OFF_TMC && wstrb_q[0]
        |=> frc_run_q == $past(wdata_q[`DPWM_BIT_FRC_RUN]))
        else $error("counter run bit not applied");
    chk_width_field: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        do_wr && (waddr_q == `DPWM_OFF_W0 || waddr_q == `DPWM_OFF_W1)
        |=> wval_q == $past(wdata_q[`DPWM_WF_MSB:`DPWM_WF_LSB]))
        else $error("width field taken from wrong bits");
    chk_width_strobe: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        do_wr && !full_word |=> wr_q == '0)
        else $error("partial width write was applied");
    chk_stat_read: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ar_hs && s_axi_araddr == `DPWM_OFF_STAT
        |=> rdata_q[15:4] == $past(frc_q) && rdata_q[3:2] == $past(pin_w))
        else $error("status read does not match the counter");

    cov_write_ordered: cover property (@(posedge ref_clk) disable iff (sys_rst)
        aw_hs && !w_hs ##[1:4] w_hs ##[1:3] bvalid_q);
    cov_fast_run: cover property (@(posedge ref_clk) disable iff (sys_rst)
        ctrl_q[`DPWM_BIT_FAST] && tick_q ##1 tick_q);
    cov_both_on: cover property (@(posedge ref_clk) disable iff (sys_rst)
        act_w == 2'h3);
    // a dropped partial write gives the strobe check something to see
    cov_width_drop: cover property (@(posedge ref_clk) disable iff (sys_rst)
        do_wr && !full_word);
endmodule : dpwm_top
`default_nettype wire

/* src/dpwm_cfg.svh */
// register map, field positions, reset values and rate counts
`ifndef DPWM_CFG_SVH
`define DPWM_CFG_SVH
`define DPWM_CHANS        2
`define DPWM_OFF_CTRL     12'h000
`define DPWM_OFF_W0       12'h004
`define DPWM_OFF_W1       12'h008
`define DPWM_OFF_TMC      12'h00C
`define DPWM_OFF_STAT     12'h010
`define DPWM_BIT_RUN0     0
`define DPWM_BIT_POL0     2
`define DPWM_BIT_SYNC0    4
`define DPWM_BIT_FAST     6
`define DPWM_BIT_FRC_RUN  3
`define DPWM_CTRL_W       7
`define DPWM_CTRL_RST     7'h00
`define DPWM_TMC_RST      1'h0
`define DPWM_WF_MSB       15
`define DPWM_WF_LSB       4
`define DPWM_DIV_SLOW     1'h1
`define DPWM_DIV_FAST     1'h0
`define DPWM_LAST_POS     8'hFF
`define DPWM_LAST_GRP     4'hF
`define DPWM_RESP_OKAY    2'h0
`define DPWM_RESP_SLVERR  2'h2
`endif

/* src/dpwm_pkg.sv */
// shared types of the dual pulse width output unit
package dpwm_pkg;
    typedef logic [1:0]  dpwm_resp_t;
    typedef logic [11:0] dpwm_width_t;
    typedef enum logic {W_IDLE, W_RESP} dpwm_wst_t;
endpackage : dpwm_pkg

/* src/dpwm_ch_if.sv */
// carrier between the register block and one output channel
`timescale 1ns/100ps
`default_nettype none
interface dpwm_ch_if;
    import dpwm_pkg::*;
    logic        tick;
    logic        frc_on;
    logic [11:0] cnt;
    logic        run;
    logic        pol;
    logic        sync;
    logic        wr;
    dpwm_width_t wdata;
    logic        pin;
    logic        active;
    modport ctl  (output tick, frc_on, cnt, run, pol, sync, wr, wdata,
                  input pin, active);
    modport chan (input tick, frc_on, cnt, run, pol, sync, wr, wdata,
                  output pin, active);
endinterface : dpwm_ch_if
`default_nettype wire

/* src/dpwm_chan.sv */
// one pulse width channel: staging, compare and pin driver
`include "dpwm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dpwm_chan (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    dpwm_ch_if.chan   ch
);
    import dpwm_pkg::*;

    dpwm_width_t stage_q;
    dpwm_width_t act_q;
    logic        run_q;
    logic        hi_q;
    logic        pin_q;
    logic        bnd;
    logic        add;
    logic [8:0]  limit;

    // update boundary: end of every cycle, or of every 16th
    assign bnd = ch.tick && ch.cnt[7:0] == `DPWM_LAST_POS &&
                 (ch.sync || ch.cnt[11:8] == `DPWM_LAST_GRP);
    // low four bits give one extra counter tick to each of the 16 cycles whose group number is at or below them, unless the upper eight bits are zero
    assign add   = ch.cnt[11:8] <= act_q[3:0];
    assign limit = {1'b0, act_q[11:4]} + {8'h00, add};

    // new width waits in staging until the boundary
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage_q <= 12'h000;
            act_q   <= 12'h000;
        end else begin
            if (ch.wr)
                stage_q <= ch.wdata;
            if (bnd)
                act_q <= stage_q;
        end
    end

    // output start waits for a boundary, stop is at once
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            run_q <= 1'b0;
        else if (!ch.run)
            run_q <= 1'b0;
        else if (bnd)
            run_q <= 1'b1;
    end

    // compare only advances on counter ticks; halted counter, no pulse
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            hi_q <= 1'b0;
        else if (!ch.frc_on)
            hi_q <= 1'b0;
        else if (ch.tick)
            hi_q <= {1'b0, ch.cnt[7:0]} < limit;
    end

    // polarity acts at once, running or not; stopped pin is a plain output
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            pin_q <= 1'b1;
        else if (run_q && ch.run && hi_q && act_q[11:4] != 8'h00)
            pin_q <= ch.pol;
        else
            pin_q <= !ch.pol;
    end

    assign ch.pin    = pin_q;
    assign ch.active = run_q;

    chk_stop_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !ch.run |=> pin_q == !$past(ch.pol))
        else $error("stopped channel not at inactive level");
    chk_zero_silent: assert property (@(posedge ref_clk) disable iff (sys_rst)
        act_q[11:4] == 8'h00 |=> pin_q == !$past(ch.pol))
        else $error("pulse seen with zero upper width");
    chk_load_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
        act_q != $past(act_q) |-> $past(bnd) && act_q == $past(stage_q))
        else $error("active width changed off boundary");
    chk_pol_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $changed(ch.pol) && !hi_q |=> pin_q == !$past(ch.pol))
        else $error("polarity change not seen on pin");
    cov_pulse: cover property (@(posedge ref_clk) disable iff (sys_rst)
        run_q && !pin_q ##1 pin_q ##[1:300] !pin_q);
endmodule : dpwm_chan
`default_nettype wire

/* test/dpwm_load.sv */
// load model on the two pulse pins: counts high clocks and rising edges
`timescale 1ns/100ps
`default_nettype none
module dpwm_load (
    input  wire logic             ref_clk,
    input  wire logic             clr,
    input  wire logic [1:0]       pin,
    output var  logic [1:0][15:0] hi_cnt,
    output var  logic [1:0][15:0] rise_cnt
);
    logic [1:0] last_q;

    // a clear opens a window; the load only listens, it never drives back
    always_ff @(posedge ref_clk) begin
        last_q <= pin;
        for (int i = 0; i < 2; i++) begin
            if (clr) begin
                hi_cnt[i] <= 16'h0000;
                rise_cnt[i] <= 16'h0000;
            end else begin
                hi_cnt[i] <= hi_cnt[i] + 16'(pin[i]);
                rise_cnt[i] <= rise_cnt[i] + 16'(pin[i] & ~last_q[i]);
            end
        end
    end
endmodule : dpwm_load
`default_nettype wire

/* test/tb.sv */
// self-checking bench of the dual pulse width output unit
`include "dpwm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dpwm_pkg::*;
    localparam logic [31:0] R0 = 32'h1 << `DPWM_BIT_RUN0;
    localparam logic [31:0] R1 = 32'h1 << (`DPWM_BIT_RUN0 + 1);
    localparam logic [31:0] P0 = 32'h1 << `DPWM_BIT_POL0;
    localparam logic [31:0] S0 = 32'h1 << `DPWM_BIT_SYNC0;
    localparam logic [31:0] FA = 32'h1 << `DPWM_BIT_FAST;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, clr = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    dpwm_resp_t bresp, rresp;
    logic [1:0] pwm_out;
    logic [1:0][15:0] hi, rise;
    int bad_count = 0;
    int n_tests = 0;

    always #25 ref_clk = ~ref_clk;

    dpwm_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_out(pwm_out));
    dpwm_load load (.ref_clk(ref_clk), .clr(clr), .pin(pwm_out),
        .hi_cnt(hi), .rise_cnt(rise));

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // both channels offered together, each released once taken
    task automatic axw(input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s = 4'hF);
        bit done;
        done = 1'b0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                chk("bresp", 32'(bresp), 32'(`DPWM_RESP_OKAY));
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axw

    task automatic axr(input logic [11:0] a, output logic [31:0] d,
                       output dpwm_resp_t r);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr

    // window of exactly n clocks seen by the load
    task automatic meas(input int n);
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : meas

    task automatic t_reset;
        logic [31:0] d;
        dpwm_resp_t r;
        chk("pins idle", 32'(pwm_out), 32'h3);
        axr(`DPWM_OFF_W0, d, r);
        chk("width read", d, 32'h0);
        chk("width resp", 32'(r), 32'(`DPWM_RESP_OKAY));
        axr(12'h020, d, r);
        chk("unmapped resp", 32'(r), 32'(`DPWM_RESP_SLVERR));
        axr(`DPWM_OFF_CTRL, d, r);
        chk("ctrl reset", d, 32'(`DPWM_CTRL_RST));
        $display("test reset done");
    endtask : t_reset

    // widths loaded first, then counter and run bits
    task automatic t_duty;
        axw(`DPWM_OFF_W0, 32'h8005);
        axw(`DPWM_OFF_W1, 32'h2000);
        axw(`DPWM_OFF_TMC, 32'h8);
        axw(`DPWM_OFF_CTRL, R0 | R1 | P0 | FA);
        repeat (8200) @(posedge ref_clk);
        meas(4096);
        chk("duty ch0", 32'(hi[0]), 32'h801);
        chk("duty ch1 low", 32'(hi[1]), 32'd4096 - 32'h201);
        chk("fast pulses", 32'(rise[0]), 32'd16);
        chk("fast pulses ch1", 32'(rise[1]), 32'd16);
        axw(`DPWM_OFF_CTRL, R0 | R1 | P0);
        repeat (600) @(posedge ref_clk);
        meas(4096);
        chk("slow pulses", 32'(rise[0]), 32'd8);
        axw(`DPWM_OFF_CTRL, R0 | R1 | FA);
        meas(4096);
        chk("pol flip run", 32'(hi[0]), 32'd4096 - 32'h801);
        $display("test duty done");
    endtask : t_duty

    // restarted counter: new width waits for the 16-cycle boundary
    task automatic t_sync0;
        axw(`DPWM_OFF_CTRL, R0 | P0 | FA);
        axw(`DPWM_OFF_TMC, 32'h0);
        axw(`DPWM_OFF_TMC, 32'h8);
        axw(`DPWM_OFF_W0, 32'h2000);
        meas(2048);
        chk("old width held", 32'(hi[0]), 32'd1025);
        repeat (4096) @(posedge ref_clk);
        meas(4096);
        chk("new width", 32'(hi[0]), 32'h201);
        $display("test sync0 done");
    endtask : t_sync0

    task automatic t_sync1;
        axw(`DPWM_OFF_CTRL, R0 | P0 | FA | S0);
        axw(`DPWM_OFF_W0, 32'h00F0);
        repeat (300) @(posedge ref_clk);
        meas(4096);
        chk("zero upper", 32'(hi[0]), 32'h0);
        axw(`DPWM_OFF_W0, 32'h8000);
        repeat (300) @(posedge ref_clk);
        meas(4096);
        chk("fast update", 32'(hi[0]), 32'h801);
        axw(`DPWM_OFF_W0, 32'h2000, 4'h1);
        repeat (300) @(posedge ref_clk);
        meas(4096);
        chk("partial width", 32'(hi[0]), 32'h801);
        $display("test sync1 done");
    endtask : t_sync1

    // stop, plain output use, then counter halt
    task automatic t_stop;
        axw(`DPWM_OFF_CTRL, P0 | FA | S0);
        repeat (2) @(posedge ref_clk);
        meas(300);
        chk("stopped high", 32'(hi[0]), 32'h0);
        axw(`DPWM_OFF_CTRL, FA | S0);
        repeat (2) @(negedge ref_clk);
        chk("gpio level", 32'(pwm_out[0]), 32'h1);
        axw(`DPWM_OFF_CTRL, R0 | P0 | FA | S0);
        repeat (300) @(posedge ref_clk);
        axw(`DPWM_OFF_TMC, 32'h0);
        meas(600);
        chk("halt pulses", 32'(rise[0]), 32'h0);
        $display("test stop done");
    endtask : t_stop

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // main sequence after a six-cycle reset
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_duty();
        t_sync0();
        t_sync1();
        t_stop();
        conclude();
    end

    // run needs about 45k clocks; a hang is cut off well past that
    initial begin
        repeat (70000) @(posedge ref_clk);
        bad_count++;
        conclude();
    end
endmodule : tb
`default_nettype wire
